// ### rtl/facm_pkg.sv
// shared constants and types for the frame access control matcher
package facm_pkg;
    localparam logic [31:0] ADDR_CTRL = 32'h00000000;
    localparam logic [31:0] ADDR_POLICY = 32'h00000004;
    localparam logic [31:0] ADDR_ACTION = 32'h00000008;
    localparam logic [31:0] ADDR_SA_LO = 32'h0000000C;
    localparam logic [31:0] ADDR_SA_HI = 32'h00000010;
    localparam logic [31:0] ADDR_DA_LO = 32'h00000014;
    localparam logic [31:0] ADDR_DA_HI = 32'h00000018;
    localparam logic [31:0] ADDR_COUNT = 32'h0000001C;
    localparam logic [31:0] ADDR_STATUS = 32'h00000020;
    // ctrl fields
    localparam int CTRL_PORT_ANY = 0;
    localparam int CTRL_PORT_LSB = 8;
    localparam int CTRL_POL_ANY = 1;
    localparam int CTRL_CLASS_LSB = 4;
    localparam int CTRL_SA_ANY = 16;
    localparam int CTRL_DA_LSB = 20;
    // action fields
    localparam int ACT_PERMIT = 0;
    localparam int ACT_MIRROR = 1;
    localparam int ACT_LOG = 2;
    localparam int ACT_SHUT = 3;
    localparam int ACT_REDIR_EN = 4;
    localparam int ACT_RATE_LSB = 8;
    localparam int ACT_REDIR_LSB = 16;
    localparam logic [31:0] CTRL_RESET = 32'h00010003;
    localparam logic [31:0] ACTION_RESET = 32'h00000001;
    localparam logic [15:0] ETYPE_MIN = 16'h0600;
    localparam logic [15:0] LEN_LIMIT = 16'h05EE;
    localparam int MAX_ENTRIES = 512;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        CLASS_ANY, CLASS_ETYPE, CLASS_ARP, CLASS_IPV4, CLASS_IPV6
    } facm_class_type;
    typedef enum logic [2:0] {
        DA_ANY, DA_MULTICAST, DA_BROADCAST, DA_UNICAST, DA_EXACT
    } facm_da_type;
endpackage

// ### rtl/facm_cfg_if.sv
// configuration carried from the register file to the comparator
`timescale 1ns/1ps
`default_nettype none
interface facm_cfg_if;
    logic port_any;
    logic [7:0] port_sel;
    logic pol_any;
    logic [7:0] pol_value;
    logic [7:0] pol_mask;
    facm_pkg::facm_class_type cls;
    logic sa_any;
    logic [47:0] sa_value;
    facm_pkg::facm_da_type da_mode;
    logic [47:0] da_value;
    modport src (output port_any, port_sel, pol_any, pol_value, pol_mask, cls, sa_any, sa_value, da_mode, da_value);
    modport dst (input port_any, port_sel, pol_any, pol_value, pol_mask, cls, sa_any, sa_value, da_mode, da_value);
endinterface
`default_nettype wire

// ### rtl/facm_compare.sv
// combinational criteria comparison for one entry
`timescale 1ns/1ps
`default_nettype none
module facm_compare (
    facm_cfg_if.dst cfg,
    input wire logic [7:0] port,
    input wire logic [7:0] policy,
    input wire facm_pkg::facm_class_type cls,
    input wire logic [15:0] len_type,
    input wire logic [47:0] sa,
    input wire logic [47:0] da,
    output logic hit
);
    logic port_ok, pol_ok, cls_ok, sa_ok, da_ok;
    always_comb begin
        port_ok = cfg.port_any || (port == cfg.port_sel); // R2
        pol_ok = cfg.pol_any || (((policy ^ cfg.pol_value) & cfg.pol_mask) == 8'h00); // R3 R6
        case (cfg.cls) // R7
            facm_pkg::CLASS_ANY: cls_ok = 1'b1;
            // ip and arp are never ethernet type frames
            facm_pkg::CLASS_ETYPE: cls_ok = (cls == facm_pkg::CLASS_ETYPE) && (len_type >= facm_pkg::ETYPE_MIN); // R8 R9
            default: cls_ok = (cls == cfg.cls); // R9
        endcase
        // source filter only meaningful for ethernet type and arp entries
        sa_ok = cfg.sa_any || !((cfg.cls == facm_pkg::CLASS_ETYPE) || (cfg.cls == facm_pkg::CLASS_ARP))
                || (sa == cfg.sa_value); // R19
        case (cfg.da_mode) // R20
            facm_pkg::DA_MULTICAST: da_ok = da[40] && (da != 48'hFFFFFFFFFFFF);
            facm_pkg::DA_BROADCAST: da_ok = (da == 48'hFFFFFFFFFFFF);
            facm_pkg::DA_UNICAST: da_ok = !da[40];
            facm_pkg::DA_EXACT: da_ok = (da == cfg.da_value);
            default: da_ok = 1'b1;
        endcase
        hit = port_ok && pol_ok && cls_ok && sa_ok && da_ok; // R1
    end
endmodule
`default_nettype wire

// ### rtl/facm_top.sv
// access control entry matcher with axi4-lite registers
// How it works
// R1: a hit needs every configured criterion to match; don't-care always matches.
// R2: ingress port criterion matches any port or one selected port.
// R3: policy don't-care matches every frame's policy number.
// R4: specific policy mode holds an 8-bit value 0 to 255.
// R5: an 8-bit bitmask selects which policy bits are compared.
// R6: policy matches when masked bits of frame and value are equal.
// R7: one class per entry: any, ethernet type, arp, ipv4, ipv6.
// R8: ethernet type class needs length/type at least 0x0600.
// R9: arp, ipv4, ipv6 frames never hit ethernet type entries.
// R10: deny hit drops the frame.
// R11: permit hit lets the frame continue through remaining actions.
// R12: rate limiting off, or one limiter 1 to 16 polices hits.
// R13: redirect enabled sends hits to the configured port.
// R14: mirroring copies hits to the mirror port; disabled after reset.
// R15: mirror copies bypass the rate limiter.
// R16: logging passes hits shorter than 1518 bytes to the system log.
// R17: shutdown disables ingress port on hits shorter than 1518 bytes.
// R18: each entry counts its hits.
// R19: source filter is don't-care or exact, only for ethernet type or arp.
// R20: destination filter: don't-care, multicast, broadcast, unicast or exact.
// R21: at most 512 entries per switch.
`timescale 1ns/1ps
`default_nettype none
module facm_top #(
    parameter int NUM_ENTRIES = 1,
    parameter int CNT_W = 32
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic FRM_VALID,
    input wire logic [7:0] FRM_PORT,
    input wire logic [7:0] FRM_POLICY,
    input wire facm_pkg::facm_class_type FRM_CLASS,
    input wire logic [15:0] FRM_LEN_TYPE,
    input wire logic [15:0] FRM_LEN,
    input wire logic [47:0] FRM_SA,
    input wire logic [47:0] FRM_DA,
    output logic RES_VALID,
    output logic RES_HIT,
    output logic RES_DROP,
    output logic RES_FWD,
    output logic RES_RATE_EN,
    output logic [3:0] RES_RATE_SEL,
    output logic RES_REDIR_EN,
    output logic [7:0] RES_REDIR_PORT,
    output logic RES_MIRROR,
    output logic RES_LOG,
    output logic RES_SHUT,
    output logic [7:0] RES_SHUT_PORT
);
    if (NUM_ENTRIES != 1 || CNT_W < 1 || CNT_W > 32 || NUM_ENTRIES > facm_pkg::MAX_ENTRIES) begin // R21
        $error("facm_top: one entry per instance, counter width 1 to 32");
    end

    logic [31:0] ctrl_q, action_q, sa_lo_q, da_lo_q;
    logic [7:0] pol_val_q, pol_mask_q;
    logic [15:0] sa_hi_q, da_hi_q;
    logic [CNT_W-1:0] count_q;
    logic [31:0] last_q;
    logic [31:0] aw_addr_q, w_data_q;
    logic [3:0] w_strb_q;
    logic aw_have_q, w_have_q;
    logic clr_cnt;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    facm_cfg_if cfg_bus();
    assign cfg_bus.port_any = ctrl_q[facm_pkg::CTRL_PORT_ANY];
    assign cfg_bus.port_sel = ctrl_q[facm_pkg::CTRL_PORT_LSB +: 8];
    assign cfg_bus.pol_any = ctrl_q[facm_pkg::CTRL_POL_ANY];
    assign cfg_bus.pol_value = pol_val_q; // R4
    assign cfg_bus.pol_mask = pol_mask_q; // R5
    assign cfg_bus.cls = facm_pkg::facm_class_type'(ctrl_q[facm_pkg::CTRL_CLASS_LSB +: 3]);
    assign cfg_bus.sa_any = ctrl_q[facm_pkg::CTRL_SA_ANY];
    assign cfg_bus.sa_value = {sa_hi_q, sa_lo_q};
    assign cfg_bus.da_mode = facm_pkg::facm_da_type'(ctrl_q[facm_pkg::CTRL_DA_LSB +: 3]);
    assign cfg_bus.da_value = {da_hi_q, da_lo_q};

    logic hit;
    facm_compare u_cmp (
        .cfg(cfg_bus),
        .port(FRM_PORT),
        .policy(FRM_POLICY),
        .cls(FRM_CLASS),
        .len_type(FRM_LEN_TYPE),
        .sa(FRM_SA),
        .da(FRM_DA),
        .hit(hit)
    );

    // write channel: address and data accepted in either order
    wire do_write = aw_have_q && w_have_q && !S_AXI_BVALID;
    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 32'h00000000;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= facm_pkg::RESP_OKAY;
        end else if (CE) begin
            S_AXI_AWREADY <= !aw_have_q && !S_AXI_AWREADY && !S_AXI_BVALID;
            S_AXI_WREADY <= !w_have_q && !S_AXI_WREADY && !S_AXI_BVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_q <= 1'b1;
                w_data_q <= S_AXI_WDATA;
                w_strb_q <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= (aw_addr_q[31:2] > facm_pkg::ADDR_STATUS[31:2]) ? facm_pkg::RESP_SLVERR
                                                                                : facm_pkg::RESP_OKAY;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // configuration registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_q <= facm_pkg::CTRL_RESET;
            action_q <= facm_pkg::ACTION_RESET; // R14
            pol_val_q <= 8'h00;
            pol_mask_q <= 8'hFF;
            sa_lo_q <= 32'h00000000;
            sa_hi_q <= 16'h0000;
            da_lo_q <= 32'h00000000;
            da_hi_q <= 16'h0000;
        end else if (CE && do_write && aw_addr_q[31:8] == 24'h000000) begin
            if (aw_addr_q[7:2] == facm_pkg::ADDR_CTRL[7:2]) begin
                ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
            end else if (aw_addr_q[7:2] == facm_pkg::ADDR_POLICY[7:2]) begin
                if (w_strb_q[0]) pol_val_q <= w_data_q[7:0];
                if (w_strb_q[1]) pol_mask_q <= w_data_q[15:8];
            end else if (aw_addr_q[7:2] == facm_pkg::ADDR_ACTION[7:2]) begin
                action_q <= merge(action_q, w_data_q, w_strb_q);
            end else if (aw_addr_q[7:2] == facm_pkg::ADDR_SA_LO[7:2]) begin
                sa_lo_q <= merge(sa_lo_q, w_data_q, w_strb_q);
            end else if (aw_addr_q[7:2] == facm_pkg::ADDR_SA_HI[7:2]) begin
                sa_hi_q <= 16'(merge({16'h0000, sa_hi_q}, w_data_q, w_strb_q));
            end else if (aw_addr_q[7:2] == facm_pkg::ADDR_DA_LO[7:2]) begin
                da_lo_q <= merge(da_lo_q, w_data_q, w_strb_q);
            end else if (aw_addr_q[7:2] == facm_pkg::ADDR_DA_HI[7:2]) begin
                da_hi_q <= 16'(merge({16'h0000, da_hi_q}, w_data_q, w_strb_q));
            end
        end
    end
    // any write to the counter word clears it
    assign clr_cnt = do_write && (aw_addr_q[31:2] == facm_pkg::ADDR_COUNT[31:2]);

    // read channel, one cycle from address to data
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (S_AXI_ARADDR[31:2] == facm_pkg::ADDR_CTRL[31:2]) begin
            rd_mux = ctrl_q;
        end else if (S_AXI_ARADDR[31:2] == facm_pkg::ADDR_POLICY[31:2]) begin
            rd_mux = {16'h0000, pol_mask_q, pol_val_q};
        end else if (S_AXI_ARADDR[31:2] == facm_pkg::ADDR_ACTION[31:2]) begin
            rd_mux = action_q;
        end else if (S_AXI_ARADDR[31:2] == facm_pkg::ADDR_SA_LO[31:2]) begin
            rd_mux = sa_lo_q;
        end else if (S_AXI_ARADDR[31:2] == facm_pkg::ADDR_SA_HI[31:2]) begin
            rd_mux = {16'h0000, sa_hi_q};
        end else if (S_AXI_ARADDR[31:2] == facm_pkg::ADDR_DA_LO[31:2]) begin
            rd_mux = da_lo_q;
        end else if (S_AXI_ARADDR[31:2] == facm_pkg::ADDR_DA_HI[31:2]) begin
            rd_mux = {16'h0000, da_hi_q};
        end else if (S_AXI_ARADDR[31:2] == facm_pkg::ADDR_COUNT[31:2]) begin
            rd_mux = 32'(count_q);
        end else if (S_AXI_ARADDR[31:2] == facm_pkg::ADDR_STATUS[31:2]) begin
            rd_mux = last_q;
        end
    end
    always_ff @(posedge CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= facm_pkg::RESP_OKAY;
        end else if (CE) begin
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_mux;
                S_AXI_RRESP <= (S_AXI_ARADDR[31:2] > facm_pkg::ADDR_STATUS[31:2]) ? facm_pkg::RESP_SLVERR
                                                                                   : facm_pkg::RESP_OKAY;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // hit counter; a hit in the clearing cycle still counts
    wire frm_hit = FRM_VALID && hit;
    always_ff @(posedge CLK) begin
        if (RST) begin
            count_q <= '0;
        end else if (CE) begin
            if (clr_cnt) begin
                count_q <= frm_hit ? CNT_W'(1) : '0; // R18
            end else if (frm_hit) begin
                count_q <= count_q + CNT_W'(1); // R18
            end
        end
    end

    // per frame verdict, registered one cycle after the frame is offered
    wire short_frm = FRM_LEN < facm_pkg::LEN_LIMIT;
    wire permit = action_q[facm_pkg::ACT_PERMIT];
    wire [3:0] rate_code = action_q[facm_pkg::ACT_RATE_LSB +: 4];
    wire rate_on = action_q[facm_pkg::ACT_RATE_LSB + 4];
    always_ff @(posedge CLK) begin
        if (RST) begin
            RES_VALID <= 1'b0;
            RES_HIT <= 1'b0;
            RES_DROP <= 1'b0;
            RES_FWD <= 1'b0;
            RES_RATE_EN <= 1'b0;
            RES_RATE_SEL <= 4'h0;
            RES_REDIR_EN <= 1'b0;
            RES_REDIR_PORT <= 8'h00;
            RES_MIRROR <= 1'b0;
            RES_LOG <= 1'b0;
            RES_SHUT <= 1'b0;
            RES_SHUT_PORT <= 8'h00;
            last_q <= 32'h00000000;
        end else if (CE) begin
            RES_VALID <= FRM_VALID;
            RES_HIT <= frm_hit;
            RES_DROP <= frm_hit && !permit; // R10
            RES_FWD <= FRM_VALID && (!hit || permit); // R11
            // limiter applies to the forwarded copy only, never to the mirror copy
            RES_RATE_EN <= frm_hit && permit && rate_on; // R12 R15
            RES_RATE_SEL <= rate_code; // R12
            RES_REDIR_EN <= frm_hit && permit && action_q[facm_pkg::ACT_REDIR_EN]; // R13
            RES_REDIR_PORT <= action_q[facm_pkg::ACT_REDIR_LSB +: 8]; // R13
            RES_MIRROR <= frm_hit && action_q[facm_pkg::ACT_MIRROR]; // R14 R15
            RES_LOG <= frm_hit && action_q[facm_pkg::ACT_LOG] && short_frm; // R16
            RES_SHUT <= frm_hit && action_q[facm_pkg::ACT_SHUT] && short_frm; // R17
            RES_SHUT_PORT <= FRM_PORT;
            if (FRM_VALID) begin
                last_q <= {23'h000000, permit, 7'h00, hit};
            end
        end
    end

    property p_drop;
        @(posedge CLK) disable iff (RST) (CE && frm_hit && !permit) |=> (RES_DROP && !RES_FWD);
    endproperty
    a_drop: assert property (p_drop) else $error("deny hit not dropped"); // R10
    property p_shut_len;
        @(posedge CLK) disable iff (RST) (RES_SHUT && $past(CE)) |-> $past(FRM_LEN) < facm_pkg::LEN_LIMIT;
    endproperty
    a_shut_len: assert property (p_shut_len) else $error("shutdown on long frame"); // R17
    property p_log_len;
        @(posedge CLK) disable iff (RST) (RES_LOG && $past(CE)) |-> ($past(FRM_LEN) < facm_pkg::LEN_LIMIT && RES_HIT);
    endproperty
    a_log_len: assert property (p_log_len) else $error("log on long frame"); // R16
    property p_count;
        @(posedge CLK) disable iff (RST) (CE && frm_hit && !clr_cnt) |=> count_q == $past(count_q) + CNT_W'(1);
    endproperty
    a_count: assert property (p_count) else $error("hit not counted"); // R18
    sequence s_no_hit_no_clr;
        CE && !frm_hit && !clr_cnt;
    endsequence
    property p_count_hold;
        @(posedge CLK) disable iff (RST) s_no_hit_no_clr |=> $stable(count_q);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("counter moved without hit"); // R18
    property p_mirror;
        @(posedge CLK) disable iff (RST) RES_MIRROR |-> RES_HIT;
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror without hit"); // R14
    property p_redir;
        @(posedge CLK) disable iff (RST) RES_REDIR_EN |-> (RES_HIT && !RES_DROP);
    endproperty
    a_redir: assert property (p_redir) else $error("redirect of dropped frame"); // R13
    property p_fwd;
        @(posedge CLK) disable iff (RST) (CE && frm_hit && permit) |=> (RES_FWD && !RES_DROP);
    endproperty
    a_fwd: assert property (p_fwd) else $error("permit hit not forwarded"); // R11
    property p_deny_extras;
        @(posedge CLK) disable iff (RST) (CE && frm_hit && !permit) |=> (!RES_RATE_EN && !RES_REDIR_EN);
    endproperty
    a_deny_extras: assert property (p_deny_extras) else $error("deny hit policed or redirected"); // R12
    property p_bcast;
        @(posedge CLK) disable iff (RST) (CE && FRM_VALID && cfg_bus.da_mode == facm_pkg::DA_BROADCAST
            && !(&FRM_DA)) |=> !RES_HIT;
    endproperty
    a_bcast: assert property (p_bcast) else $error("non broadcast frame hit"); // R20
    property p_etype;
        @(posedge CLK) disable iff (RST) (CE && FRM_VALID && cfg_bus.cls == facm_pkg::CLASS_ETYPE
            && FRM_CLASS != facm_pkg::CLASS_ETYPE) |=> !RES_HIT;
    endproperty
    a_etype: assert property (p_etype) else $error("non ethernet type frame hit"); // R9
    property p_port;
        @(posedge CLK) disable iff (RST) (CE && FRM_VALID && !cfg_bus.port_any && FRM_PORT != cfg_bus.port_sel)
            |=> !RES_HIT;
    endproperty
    a_port: assert property (p_port) else $error("wrong port hit"); // R2
endmodule
`default_nettype wire

// ### verif/facm_parser_model.sv
// ingress parser stand-in presenting one frame per cycle
`timescale 1ns/1ps
`default_nettype none
module facm_parser_model (
    input wire logic clk,
    output logic frm_valid,
    output logic [7:0] frm_port,
    output logic [7:0] frm_policy,
    output facm_pkg::facm_class_type frm_class,
    output logic [15:0] frm_len_type,
    output logic [15:0] frm_len,
    output logic [47:0] frm_sa,
    output logic [47:0] frm_da
);
    initial begin
        frm_valid = 1'b0;
        frm_class = facm_pkg::CLASS_ANY;
        {frm_port, frm_policy, frm_len_type, frm_len, frm_sa, frm_da} = '0;
    end
    // called just after an edge; the frame is taken at the next one
    task automatic send(input logic [7:0] p, pol, input logic [2:0] c, input logic [15:0] lt, len,
                        input logic [47:0] s, d);
        frm_valid <= 1'b1;
        frm_port <= p;
        frm_policy <= pol;
        frm_class <= facm_pkg::facm_class_type'(c);
        frm_len_type <= lt;
        frm_len <= len;
        frm_sa <= s;
        frm_da <= d;
        @(posedge clk);
    endtask
    // released fields flip so a stale frame never looks valid
    task automatic idle();
        frm_valid <= 1'b0;
        {frm_port, frm_policy, frm_len_type, frm_len, frm_sa, frm_da} <=
            ~{frm_port, frm_policy, frm_len_type, frm_len, frm_sa, frm_da};
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ### verif/frame_access_control_matcher_tb_top.sv
// self-checking bench for the access control entry matcher
`timescale 1ns/1ps
`default_nettype none
module frame_access_control_matcher_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
    logic [31:0] aw_a = '0, w_d = '0, ar_a = '0;
    logic [3:0] w_s = 4'hF;
    wire logic aw_rdy, w_rdy, b_v, ar_rdy, r_v;
    wire logic [1:0] b_resp, r_resp;
    wire logic [31:0] r_data;
    wire logic f_v;
    wire logic [7:0] f_port, f_pol;
    wire facm_pkg::facm_class_type f_cls;
    wire logic [15:0] f_lt, f_len;
    wire logic [47:0] f_sa, f_da;
    wire logic o_v, o_hit, o_drop, o_fwd, o_re, o_rd, o_mir, o_log, o_sh;
    wire logic [3:0] o_rs;
    wire logic [7:0] o_rp, o_sp;
    int num_errors = 0;
    int n_checks = 0;
    int hits;
    integer seed = 32'h950e;
    logic [31:0] cfgv [8];
    logic [31:0] rd, r1, r2;
    logic [1:0] rsp;
    logic [7:0] fp, fpl;
    logic [2:0] fc;
    logic [15:0] flt, fln;
    logic [47:0] fs, fd;
    logic [27:0] e;
    logic [27:0] exp_q [$];
    logic [31:0] fmask [8] = '{32'h0001FF03, 32'h0000FFFF, 32'h00FF1F1F, 32'hFFFFFFFF, 32'h0000FFFF,
                               32'hFFFFFFFF, 32'h0000FFFF, 32'h0};

    always #4 clk = ~clk;

    facm_top u_dut (.CLK(clk), .RST(rst), .CE(ce),
        .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(w_d), .S_AXI_WSTRB(w_s),
        .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r),
        .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(r_data),
        .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r),
        .FRM_VALID(f_v), .FRM_PORT(f_port), .FRM_POLICY(f_pol), .FRM_CLASS(f_cls), .FRM_LEN_TYPE(f_lt),
        .FRM_LEN(f_len), .FRM_SA(f_sa), .FRM_DA(f_da), .RES_VALID(o_v), .RES_HIT(o_hit), .RES_DROP(o_drop),
        .RES_FWD(o_fwd), .RES_RATE_EN(o_re), .RES_RATE_SEL(o_rs), .RES_REDIR_EN(o_rd), .RES_REDIR_PORT(o_rp),
        .RES_MIRROR(o_mir), .RES_LOG(o_log), .RES_SHUT(o_sh), .RES_SHUT_PORT(o_sp));

    facm_parser_model u_src (.clk(clk), .frm_valid(f_v), .frm_port(f_port), .frm_policy(f_pol),
        .frm_class(f_cls), .frm_len_type(f_lt), .frm_len(f_len), .frm_sa(f_sa), .frm_da(f_da));

    task automatic chk_val(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_res(input logic [27:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t result %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic axw(input logic [31:0] a, d, output logic [1:0] r);
        @(posedge clk);
        aw_v <= 1'b1;
        w_v <= 1'b1;
        aw_a <= a;
        w_d <= d;
        b_r <= 1'b1;
        do begin
            @(posedge clk);
            if (aw_rdy) aw_v <= 1'b0;
            if (w_rdy) w_v <= 1'b0;
        end while (b_v !== 1'b1);
        r = b_resp;
        b_r <= 1'b0;
    endtask
    task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ar_v <= 1'b1;
        ar_a <= a;
        r_r <= 1'b1;
        do begin
            @(posedge clk);
            if (ar_rdy) ar_v <= 1'b0;
        end while (r_v !== 1'b1);
        d = r_data;
        r = r_resp;
        r_r <= 1'b0;
    endtask

    // disabled fields are don't-care on the wire, so they are zeroed before comparing
    function automatic logic [27:0] seen();
        return {o_hit, o_drop, o_fwd, o_re, o_re ? o_rs : 4'h0, o_rd, o_rd ? o_rp : 8'h0, o_mir, o_log, o_sh,
                o_sh ? o_sp : 8'h0};
    endfunction
    function automatic logic [27:0] model(logic [7:0] p, pol, logic [2:0] c, logic [15:0] lt, len,
                                          logic [47:0] s, d);
        logic [31:0] a;
        logic [2:0] cc;
        logic m, pm, sh;
        a = cfgv[2];
        cc = cfgv[0][6:4];
        m = (cfgv[0][0] || p == cfgv[0][15:8]) && (cfgv[0][1] || ((pol ^ cfgv[1][7:0]) & cfgv[1][15:8]) == 8'h0);
        if (cc == 3'd1) m &= (c == 3'd1) && (lt >= facm_pkg::ETYPE_MIN);
        else if (cc != 3'd0) m &= (c == cc);
        if ((cc == 3'd1 || cc == 3'd2) && !cfgv[0][16]) m &= (s == {cfgv[4][15:0], cfgv[3]});
        case (cfgv[0][22:20])
            3'd1: m &= d[40] && !(&d);
            3'd2: m &= &d;
            3'd3: m &= !d[40];
            3'd4: m &= d == {cfgv[6][15:0], cfgv[5]};
            default: ;
        endcase
        pm = m && a[0];
        sh = m && len < 16'd1518;
        return {m, m && !a[0], !m || a[0], pm && a[12], (pm && a[12]) ? a[11:8] : 4'h0, pm && a[4],
                (pm && a[4]) ? a[23:16] : 8'h0, m && a[1], sh && a[2], sh && a[3], (sh && a[3]) ? p : 8'h0};
    endfunction

    always @(negedge clk) begin
        if (o_v === 1'b1) chk_res(seen(), exp_q.size() > 0 ? exp_q.pop_front() : ~seen());
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        axr(facm_pkg::ADDR_CTRL, rd, rsp);
        chk_val(rd, facm_pkg::CTRL_RESET);
        axr(facm_pkg::ADDR_ACTION, rd, rsp);
        chk_val(rd, facm_pkg::ACTION_RESET);
        axr(32'h00000024, rd, rsp);
        chk_val({rd[31:2], rd[1:0] | rsp}, {30'h0, facm_pkg::RESP_SLVERR});
        axw(32'h00000024, 32'hFFFFFFFF, rsp);
        chk_val(32'(rsp), 32'(facm_pkg::RESP_SLVERR));
        for (int i = 0; i < 10; i++) begin
            for (int k = 0; k < 8; k++) cfgv[k] = $random(seed) & fmask[k];
            cfgv[0][6:4] = 3'(i % 5);
            cfgv[0][22:20] = 3'((i + 2) % 5);
            for (int k = 0; k < 8; k++) begin
                axw(32'(4 * k), cfgv[k], rsp);
                chk_val(32'(rsp), 32'(facm_pkg::RESP_OKAY));
            end
            hits = 0;
            for (int j = 0; j < 40; j++) begin
                r1 = $random(seed);
                r2 = $random(seed);
                fp = r1[0] ? cfgv[0][15:8] : r2[7:0];
                fpl = r1[1] ? cfgv[1][7:0] : r2[15:8];
                fc = 3'(r1[3:2]) + 3'd1;
                flt = r1[5:4] == 2'd0 ? 16'h05FF : r1[5:4] == 2'd1 ? 16'h0600 : r2[31:16];
                fln = r1[7:6] == 2'd0 ? 16'd1517 : r1[7:6] == 2'd1 ? 16'd1518 : {5'h0, r2[10:0]};
                fs = r1[8] ? {cfgv[4][15:0], cfgv[3]} : {r2, r1[31:16]};
                fd = r1[10:9] == 2'd0 ? {cfgv[6][15:0], cfgv[5]}
                    : r1[10:9] == 2'd1 ? 48'hFFFFFFFFFFFF : {7'h0, r1[11], r2, 8'h0};
                e = model(fp, fpl, fc, flt, fln, fs, fd);
                hits += e[27];
                exp_q.push_back(e);
                u_src.send(fp, fpl, fc, flt, fln, fs, fd);
                if (r1[12]) u_src.idle();
            end
            u_src.idle();
            // frozen cycles: the offered frame is neither judged nor counted
            ce <= 1'b0;
            u_src.send(fp, fpl, fc, flt, fln, fs, fd);
            u_src.idle();
            ce <= 1'b1;
            repeat (2) @(posedge clk);
            axr(facm_pkg::ADDR_COUNT, rd, rsp);
            chk_val(rd, 32'(hits));
            axr(facm_pkg::ADDR_STATUS, rd, rsp);
            chk_val(rd, {23'h0, cfgv[2][0], 7'h0, e[27]});
        end
        chk_val(32'(exp_q.size()), 32'h0);
        summarize();
    end

    // run needs roughly 1200 cycles; generous margin before declaring a hang
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
